/* hw/scb_pkg.sv */
/*
 * Shared constants for the type-B switched-capacitor control-0 bank:
 * register byte offsets, field positions, reset values and widths.
 * Assumes a 32-bit AHB-Lite register bus with one register per word.
 */
package scb_pkg;
   // Number of type-B blocks served by the bank
   localparam int SCB_BLOCKS = 4;
   // Control-0 byte offsets, one per block
   localparam logic [7:0] SCB_OFF_B11_CTRL0 = 8'h84;
   localparam logic [7:0] SCB_OFF_B13_CTRL0 = 8'h8C;
   localparam logic [7:0] SCB_OFF_B20_CTRL0 = 8'h90;
   localparam logic [7:0] SCB_OFF_B22_CTRL0 = 8'h98;
   // Clock select, bus drive enable and status words
   localparam logic [7:0] SCB_OFF_CLK_SEL = 8'h60;
   localparam logic [7:0] SCB_OFF_DRIVE_EN = 8'h64;
   localparam logic [7:0] SCB_OFF_STATUS = 8'h68;
   // Control-0 field positions
   localparam int SCB_FEEDBACK_CAP_SIZE_BIT = 7;
   localparam int SCB_PHASE_INV_BIT = 6;
   localparam int SCB_A_SAMPLE_POLARITY_BIT = 5;
   localparam int SCB_A_CAP_UNITS_MSB = 4;
   // Sample-and-hold disable position in clock select
   localparam int SCB_SHD_BIT = 6;
   // Reset values
   localparam logic [7:0] SCB_CTRL0_RST = 8'h00;
   localparam logic [7:0] SCB_CLK_SEL_RST = 8'h00;
   localparam logic [3:0] SCB_DRIVE_EN_RST = 4'h0;
   // Feedback capacitor sizes in unit capacitors
   localparam logic [5:0] SCB_FEEDBACK_CAP_SIZE_SMALL = 6'h10;
   localparam logic [5:0] SCB_FEEDBACK_CAP_SIZE_LARGE = 6'h20;
   // Register select codes
   localparam logic [2:0] SCB_SEL_NONE = 3'h0;
   localparam logic [2:0] SCB_SEL_CTRL = 3'h1;
   localparam logic [2:0] SCB_SEL_CLK = 3'h2;
   localparam logic [2:0] SCB_SEL_DRV = 3'h3;
   localparam logic [2:0] SCB_SEL_STAT = 3'h4;
endpackage

/* hw/scb_phase_unit.sv */
/*
 * Per-block phase logic: internal phase selection, A-plate switching,
 * output bus window, comparator latch and capacitor size outputs.
 * Assumes phase and comparator inputs are already synchronised to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module scb_phase_unit
   import scb_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Control
   input wire logic [7:0] ctrl_i,
   input wire logic shd_i,
   input wire logic drive_en_i,
   input wire logic late_half_i,
   // Synchronised external phases and comparator
   input wire logic p1_i,
   input wire logic p2_i,
   input wire logic cmp_i,
   // Switch controls
   output logic int_p1_o,
   output logic int_p2_o,
   output logic a_in_o,
   output logic a_ref_o,
   output logic bus_connect_o,
   output logic cmp_bus_o,
   output logic [5:0] fb_units_o,
   output logic [4:0] a_units_o
);
   import scb_pkg::*;

   logic p1_q; // Previous phase one
   logic p2_q; // Previous phase two
   logic boundary; // Either phase changed
   logic [7:0] act; // Control copy in use
   logic [7:0] next_act;
   logic ip1; // Internal phase one
   logic ip2; // Internal phase two
   logic cap; // Captured comparator value

   assign boundary = (p1_i != p1_q) || (p2_i != p2_q);
   assign next_act = boundary ? ctrl_i : act;
   assign ip1 = next_act[SCB_PHASE_INV_BIT] ? p2_i : p1_i;
   assign ip2 = next_act[SCB_PHASE_INV_BIT] ? p1_i : p2_i;

   // Phase history and active control copy
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         p1_q <= 1'b0;
         p2_q <= 1'b0;
         act <= SCB_CTRL0_RST;
      end else begin
         p1_q <= p1_i;
         p2_q <= p2_i;
         act <= next_act;
      end
   end

   // Switch outputs, all registered to avoid decode glitches
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         int_p1_o <= 1'b0;
         int_p2_o <= 1'b0;
         a_in_o <= 1'b0;
         a_ref_o <= 1'b0;
         fb_units_o <= SCB_FEEDBACK_CAP_SIZE_SMALL;
         a_units_o <= 5'h00;
      end else begin
         int_p1_o <= ip1;
         int_p2_o <= ip2;
         a_in_o <= next_act[SCB_A_SAMPLE_POLARITY_BIT] ? ip2 : ip1;
         a_ref_o <= next_act[SCB_A_SAMPLE_POLARITY_BIT] ? ip1 : ip2;
         fb_units_o <= next_act[SCB_FEEDBACK_CAP_SIZE_BIT] ? SCB_FEEDBACK_CAP_SIZE_LARGE
                                              : SCB_FEEDBACK_CAP_SIZE_SMALL;
         a_units_o <= next_act[SCB_A_CAP_UNITS_MSB:0];
      end
   end

   // Output bus window
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         bus_connect_o <= 1'b0;
      end else begin
         bus_connect_o <= drive_en_i && ip2 && (shd_i
            || next_act[SCB_PHASE_INV_BIT] || late_half_i);
      end
   end

   // Comparator latch: capture on falling int p2, show on rising int p1
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cap <= 1'b0;
         cmp_bus_o <= 1'b0;
      end else begin
         if (int_p2_o && !ip2) begin
            cap <= cmp_i;
         end
         if (!int_p1_o && ip1) begin
            cmp_bus_o <= cap;
         end
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   AST_FB_LARGE: assert property (boundary && ctrl_i[SCB_FEEDBACK_CAP_SIZE_BIT]
      |=> fb_units_o == SCB_FEEDBACK_CAP_SIZE_LARGE) else $error("feedback_cap_size not 32");
   AST_SWAP: assert property (next_act[SCB_PHASE_INV_BIT] && p1_i
      && !p2_i |=> int_p2_o && !int_p1_o) else $error("phase swap bad");
   AST_EARLY_OFF: assert property (!shd_i && !late_half_i
      && !next_act[SCB_PHASE_INV_BIT] |=> !bus_connect_o)
      else $error("bus driven early");
   AST_INV_WHOLE: assert property (drive_en_i
      && next_act[SCB_PHASE_INV_BIT] && ip2 |=> bus_connect_o)
      else $error("inverted window short");
   AST_SHD_WHOLE: assert property (drive_en_i && shd_i && ip2
      |=> bus_connect_o) else $error("shd window short");
   AST_CAPTURE: assert property (int_p2_o && !ip2
      |=> cap == $past(cmp_i)) else $error("capture missed");
   AST_INV_OUT: assert property (act[SCB_PHASE_INV_BIT]
      && next_act[SCB_PHASE_INV_BIT] && !(p2_i && !p2_q)
      |=> $stable(cmp_bus_o)) else $error("inverted column_comparator_bus off p2 rise");
   AST_CMP_STABLE: assert property (!(!int_p1_o && ip1)
      |=> $stable(cmp_bus_o)) else $error("column_comparator_bus moved");
   AST_APLATE: assert property (!next_act[SCB_A_SAMPLE_POLARITY_BIT] && ip1
      |=> a_in_o && !a_ref_o) else $error("a plate phase bad");
   AST_HOLD_CTRL: assert property (!boundary
      |=> $stable(a_units_o) && $stable(fb_units_o))
      else $error("control changed mid phase");
endmodule
`default_nettype wire

/* hw/scb_ctrl0_bank.sv */
/*
 * Control-0 register bank and clock-phase logic for four type-B
 * switched-capacitor blocks, reached as an AHB-Lite slave.
 * Assumes phase clocks and comparator outputs arrive asynchronously
 * from the analog array and are resynchronised here.
 */
//Contract
// - Feedback bit picks 16 or 32 units
// - Invert bit swaps internal phase clocks
// - Normal block connects only late phase two unless sample-hold disabled
// - Inverted block connects whole phase two
// - Sample-hold disable connects whole phase two
// - Normal: capture fall p2, show rise p1
// - Inverted: capture fall p1, show rise p2
// - Comparator bus changes only at output
// - Sign bit swaps input and reference phases
// - A size field is plain binary
// - Registers at 84h 8Ch 90h 98h
// - Block drives latched result on column bus
`timescale 1ns/1ps
`default_nettype none
module scb_ctrl0_bank
   import scb_pkg::*;
#(
   parameter int CNT_W = 12 // Phase-two length counter width
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // External phase clocks from the clock generator
   input wire logic phase_one_clock_i,
   input wire logic phase_two_clock_i,
   // Raw comparator outputs, one per block
   input wire logic [3:0] cmp_raw_i,
   // Switch network controls, one lane per block
   output logic [3:0] int_phase_one_o,
   output logic [3:0] int_phase_two_o,
   output logic [3:0] a_plate_input_o,
   output logic [3:0] a_plate_ref_o,
   output logic [3:0] column_analog_bus_connect_o,
   output logic [3:0] column_comparator_bus_o,
   output logic [3:0][5:0] feedback_cap_units_o,
   output logic [3:0][4:0] a_cap_units_o
);
   import scb_pkg::*;

   logic [7:0] ctrl0 [SCB_BLOCKS]; // Control-0 registers
   logic [7:0] clk_sel; // Analog clock select
   logic [3:0] column_bus_drive_enable; // Per-block bus enable
   logic sample_hold_disable; // Global window override
   logic addr_take; // Address phase accepted
   logic wr_pend; // Write data phase pending
   logic [2:0] wr_sel; // Latched write target
   logic [1:0] wr_idx; // Latched block index
   logic [2:0] rd_sel; // Decoded read target
   logic [1:0] rd_idx;
   logic [5:0] sync_meta; // First sync stage, read by stage two only
   logic [5:0] sync_q; // Second sync stage
   logic p1_s; // Synced phase one
   logic p2_s; // Synced phase two
   logic [3:0] cmp_s; // Synced comparators
   logic [CNT_W-1:0] p2_cnt; // Cycles into current phase two
   logic [CNT_W-1:0] p2_len; // Length of previous phase two
   logic late_half; // Past the midpoint of phase two
   logic [31:0] next_rdata;

   assign sample_hold_disable = clk_sel[SCB_SHD_BIT];
   assign p1_s = sync_q[4];
   assign p2_s = sync_q[5];
   assign cmp_s = sync_q[3:0];
   // Zero wait states, always OKAY
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign addr_take = hsel_i && htrans_i[1] && hready_i;

   // Offset decode; the bank bit and upper address bits are ignored
   function automatic logic [2:0] reg_sel(input logic [31:0] a);
      logic [7:0] off;
      off = a[7:0];
      if (off == SCB_OFF_B11_CTRL0 || off == SCB_OFF_B13_CTRL0
          || off == SCB_OFF_B20_CTRL0 || off == SCB_OFF_B22_CTRL0) begin
         reg_sel = SCB_SEL_CTRL;
      end else if (off == SCB_OFF_CLK_SEL) begin
         reg_sel = SCB_SEL_CLK;
      end else if (off == SCB_OFF_DRIVE_EN) begin
         reg_sel = SCB_SEL_DRV;
      end else if (off == SCB_OFF_STATUS) begin
         reg_sel = SCB_SEL_STAT;
      end else begin
         reg_sel = SCB_SEL_NONE;
      end
   endfunction

   // Block index for a control-0 offset
   function automatic logic [1:0] reg_idx(input logic [31:0] a);
      logic [7:0] off;
      off = a[7:0];
      if (off == SCB_OFF_B13_CTRL0) begin
         reg_idx = 2'h1;
      end else if (off == SCB_OFF_B20_CTRL0) begin
         reg_idx = 2'h2;
      end else if (off == SCB_OFF_B22_CTRL0) begin
         reg_idx = 2'h3;
      end else begin
         reg_idx = 2'h0;
      end
   endfunction

   assign rd_sel = reg_sel(haddr_i);
   assign rd_idx = reg_idx(haddr_i);

   // Two-flop synchronisers for phases and comparators
   // One shared stage keeps the skew between phases and comparators fixed
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sync_meta <= 6'h00;
         sync_q <= 6'h00;
      end else begin
         sync_meta <= {phase_two_clock_i, phase_one_clock_i, cmp_raw_i};
         sync_q <= sync_meta;
      end
   end

   // Address phase capture for writes
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wr_pend <= 1'b0;
         wr_sel <= SCB_SEL_NONE;
         wr_idx <= 2'h0;
      end else begin
         wr_pend <= addr_take && hwrite_i;
         if (addr_take) begin
            wr_sel <= rd_sel;
            wr_idx <= rd_idx;
         end
      end
   end

   // Control-0 writes in the data phase
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         for (int i = 0; i < SCB_BLOCKS; i++) begin
            ctrl0[i] <= SCB_CTRL0_RST;
         end
      end else if (wr_pend && wr_sel == SCB_SEL_CTRL) begin
         ctrl0[wr_idx] <= hwdata_i[7:0];
      end
   end

   // Clock select and drive enable writes
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         clk_sel <= SCB_CLK_SEL_RST;
         column_bus_drive_enable <= SCB_DRIVE_EN_RST;
      end else if (wr_pend) begin
         if (wr_sel == SCB_SEL_CLK) begin
            clk_sel <= hwdata_i[7:0];
         end
         if (wr_sel == SCB_SEL_DRV) begin
            column_bus_drive_enable <= hwdata_i[3:0];
         end
      end
   end

   // Read mux; unmapped offsets read zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      unique case (rd_sel)
         SCB_SEL_CTRL: next_rdata = {24'h00_0000, ctrl0[rd_idx]};
         SCB_SEL_CLK: next_rdata = {24'h00_0000, clk_sel};
         SCB_SEL_DRV: next_rdata = {28'h000_0000, column_bus_drive_enable};
         SCB_SEL_STAT: next_rdata = {22'h00_0000, p2_s, p1_s,
            column_analog_bus_connect_o, column_comparator_bus_o};
         default: next_rdata = 32'h0000_0000;
      endcase
      // A write still in its data phase has not reached its register yet,
      // so a pipelined read of the same word takes the byte on the bus
      if (wr_pend && wr_sel == rd_sel && wr_idx == rd_idx) begin
         if (rd_sel == SCB_SEL_CTRL || rd_sel == SCB_SEL_CLK) begin
            next_rdata = {24'h00_0000, hwdata_i[7:0]};
         end else if (rd_sel == SCB_SEL_DRV) begin
            next_rdata = {28'h000_0000, hwdata_i[3:0]};
         end
      end
   end

   // Read data registered at the address phase, valid in data phase
   // It stands until the next read address phase
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         hrdata_o <= 32'h0000_0000;
      end else if (addr_take && !hwrite_i) begin
         hrdata_o <= next_rdata;
      end
   end

   // Phase-two length meter; saturates rather than wrapping
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         p2_cnt <= '0;
         p2_len <= '0;
      end else if (p2_s) begin
         if (p2_cnt != {CNT_W{1'b1}}) begin
            p2_cnt <= p2_cnt + 1'b1;
         end
      end else begin
         if (p2_cnt != '0) begin
            p2_len <= p2_cnt;
         end
         p2_cnt <= '0;
      end
   end

   // second half of phase two
   // Uses the last phase length, so the first phase after reset stays off
   assign late_half = p2_s && (p2_len != '0)
      && (p2_cnt >= (p2_len >> 1));

   // One phase unit per block
   for (genvar g = 0; g < SCB_BLOCKS; g++) begin : g_unit
      scb_phase_unit u_unit (
         .clk_i(clk_i),
         .resetn_i(resetn_i),
         .ctrl_i(ctrl0[g]),
         .shd_i(sample_hold_disable),
         .drive_en_i(column_bus_drive_enable[g]),
         .late_half_i(late_half),
         .p1_i(p1_s),
         .p2_i(p2_s),
         .cmp_i(cmp_s[g]),
         .int_p1_o(int_phase_one_o[g]),
         .int_p2_o(int_phase_two_o[g]),
         .a_in_o(a_plate_input_o[g]),
         .a_ref_o(a_plate_ref_o[g]),
         .bus_connect_o(column_analog_bus_connect_o[g]),
         .cmp_bus_o(column_comparator_bus_o[g]),
         .fb_units_o(feedback_cap_units_o[g]),
         .a_units_o(a_cap_units_o[g])
      );
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   AST_CTRL_WRITE: assert property (addr_take && hwrite_i
      && haddr_i[7:0] == SCB_OFF_B20_CTRL0 ##1 1'b1
      |=> ctrl0[2] == $past(hwdata_i[7:0]))
      else $error("ctrl0 block20 write lost");

   AST_CTRL_READ: assert property (addr_take && !hwrite_i
      && haddr_i[7:0] == SCB_OFF_B11_CTRL0
      && !(wr_pend && wr_sel == SCB_SEL_CTRL && wr_idx == 2'h0)
      |=> hrdata_o == {24'h00_0000, $past(ctrl0[0])})
      else $error("ctrl0 block11 read wrong");

   AST_UNMAPPED: assert property (addr_take && !hwrite_i
      && rd_sel == SCB_SEL_NONE |=> hrdata_o == 32'h0000_0000)
      else $error("unmapped read not zero");

   AST_LATE_HALF: assert property (!p2_s |-> !late_half)
      else $error("late half outside phase two");

   AST_DRV_OFF: assert property (column_bus_drive_enable == 4'h0
      |=> column_analog_bus_connect_o == 4'h0)
      else $error("bus connected without drive enable");

   AST_INV_CMP: assert property ($changed(column_comparator_bus_o[1])
      |-> $rose(int_phase_one_o[1])) else $error("column_comparator_bus moved off output edge");

   AST_STAT_READ: assert property (addr_take && !hwrite_i
      && rd_sel == SCB_SEL_STAT |=> hrdata_o[7:0]
      == $past({column_analog_bus_connect_o, column_comparator_bus_o}))
      else $error("status read wrong");

   // Main scenarios
   COV_WRITE: cover property (wr_pend && wr_sel == SCB_SEL_CTRL);
   COV_CONNECT: cover property ($rose(column_analog_bus_connect_o[0]));
   COV_CMP: cover property ($changed(column_comparator_bus_o[1]));
   COV_SHD: cover property (sample_hold_disable
      && |column_analog_bus_connect_o);
   COV_INV_OUT: cover property ($changed(column_comparator_bus_o[3]));
endmodule
`default_nettype wire

/* tb/scb_analog_model.sv */
/*
 * Far side model: clock generator making two non-overlapping phase
 * clocks, and the comparators of the four type-B blocks.
 * Assumes the bench sets comparator levels away from phase edges.
 */
`timescale 1ns/1ps
`default_nettype none
module scb_analog_model #(
   parameter int PH_HIGH = 16, // Cycles each phase stays high
   parameter int PH_GAP = 2 // Non-overlap gap after each phase
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Comparator levels commanded by the bench
   input wire logic [3:0] cmp_val_i,
   // Phase clocks and comparator outputs toward the bank
   output logic phase_one_clock_o,
   output logic phase_two_clock_o,
   output logic [3:0] cmp_raw_o
);
   localparam int PERIOD = 2 * (PH_HIGH + PH_GAP);
   logic [7:0] cnt; // Position within one phase period
   // Free-running period counter; the phase clocks never stop
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt <= 8'h00;
      end else if (cnt == 8'(PERIOD - 1)) begin
         cnt <= 8'h00;
      end else begin
         cnt <= cnt + 8'h01;
      end
   end
   // Gaps keep the two phases from ever overlapping
   assign phase_one_clock_o = (cnt < 8'(PH_HIGH));
   assign phase_two_clock_o = (cnt >= 8'(PH_HIGH + PH_GAP)) &&
      (cnt < 8'(2 * PH_HIGH + PH_GAP));
   // Comparators always drive a settled level
   assign cmp_raw_o = cmp_val_i;
endmodule
`default_nettype wire

/* tb/tb.sv */
/*
 * Self-checking bench for the control-0 bank: AHB-Lite master tasks,
 * register checks and phase-timed checks of the switch outputs.
 * Assumes the far side model makes 16-cycle phases with 2-cycle gaps.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
   import scb_pkg::*;
   // Clock, reset and bus master
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hready; // Single slave, so its ready is the bus ready
   logic hresp;
   // Far side and switch outputs
   logic ph1;
   logic ph2;
   logic [3:0] cmp_val = 4'h0;
   logic [3:0] cmp_raw;
   logic [3:0] ip1, ip2, a_in, a_ref, bus_con, column_comparator_bus;
   logic [3:0][5:0] fb;
   logic [3:0][4:0] au;
   // Counters and scratch
   int failures = 0;
   int checks = 0;
   int cyc = 0;
   logic [31:0] rd;
   // Lanes: normal, inverted, normal with sign, inverted with sign
   logic [7:0] cfg [4] = '{8'h1F, 8'hC0, 8'h30, 8'hE1};
   logic [7:0] offs [4] = '{SCB_OFF_B11_CTRL0, SCB_OFF_B13_CTRL0,
      SCB_OFF_B20_CTRL0, SCB_OFF_B22_CTRL0};

   scb_ctrl0_bank i_dut (.clk_i(clk_i), .resetn_i(resetn_i),
      .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
      .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
      .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
      .hresp_o(hresp), .phase_one_clock_i(ph1),
      .phase_two_clock_i(ph2), .cmp_raw_i(cmp_raw),
      .int_phase_one_o(ip1), .int_phase_two_o(ip2),
      .a_plate_input_o(a_in), .a_plate_ref_o(a_ref),
      .column_analog_bus_connect_o(bus_con),
      .column_comparator_bus_o(column_comparator_bus), .feedback_cap_units_o(fb),
      .a_cap_units_o(au));
   scb_analog_model i_far (.clk_i(clk_i), .resetn_i(resetn_i),
      .cmp_val_i(cmp_val), .phase_one_clock_o(ph1),
      .phase_two_clock_o(ph2), .cmp_raw_o(cmp_raw));

   // 200 MHz clock
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end

   // Hang guard, about ten times the few phase periods the tests need
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 2000) begin
         failures++;
         tally_and_finish();
      end
   end

   // One compare, counted
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got,
            exp);
      end
   endtask

   // One single AHB-Lite transfer, entered just after a clock edge
   task automatic ahb(input logic wr, input logic [31:0] a,
      input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      @(posedge clk_i);
      while (hready !== 1'b1) @(posedge clk_i);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk_i);
      while (hready !== 1'b1) @(posedge clk_i);
      rd = hrdata;
   endtask

   // Wait for a phase to rise at the pin, then n cycles more
   task automatic wait_p(input logic two, input int n);
      if (two) @(posedge ph2);
      else @(posedge ph1);
      repeat (n) @(posedge clk_i);
   endtask

   task automatic tally_and_finish();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      repeat (10) @(posedge clk_i);
      resetn_i <= 1'b1;
      @(posedge clk_i);
      // Per block: control-0 reset value, then write and read back; after the blocks, clock select reset value
      for (int b = 0; b < 4; b++) begin
         ahb(1'b0, 32'(offs[b]), 32'h0);
         chk(rd, 32'h0);
         ahb(1'b1, 32'(offs[b]), {24'hFFFFFF, cfg[b]});
         ahb(1'b0, 32'(offs[b]), 32'h0);
         chk(rd, 32'(cfg[b]));
         ahb(1'b0, 32'h100 | 32'(offs[b]), 32'h0);
         chk(rd, 32'(cfg[b]));
      end
      ahb(1'b0, 32'(SCB_OFF_CLK_SEL), 32'h0);
      chk(rd, 32'h0);
      chk(32'(hresp), 32'h0);
      // Unmapped place ignores writes and reads zero
      ahb(1'b1, 32'h70, 32'hFF);
      ahb(1'b0, 32'h70, 32'h0);
      chk(rd, 32'h0);
      ahb(1'b1, 32'(SCB_OFF_DRIVE_EN), 32'hF);
      // Early second phase: fields, phases, plates, bus open
      wait_p(1'b1, 0);
      wait_p(1'b1, 6);
      for (int b = 0; b < 4; b++) begin
         chk(32'(fb[b]), cfg[b][7] ? 32'h20 : 32'h10);
         chk(32'(au[b]), 32'(cfg[b][4:0]));
      end
      chk(32'(ip1), 32'hA);
      chk(32'(ip2), 32'h5);
      chk(32'(a_in), 32'h6);
      chk(32'(a_ref), 32'h9);
      chk(32'(bus_con), 32'h0);
      cmp_val <= 4'h3;
      // Late half of the second phase closes normal lanes
      repeat (9) @(posedge clk_i);
      chk(32'(bus_con), 32'h5);
      // Inverted lanes connect for their whole internal second phase
      wait_p(1'b0, 10);
      chk(32'(bus_con), 32'hA);
      chk(32'(column_comparator_bus & 4'h5), 32'h1);
      cmp_val <= 4'hC;
      // Normal lanes hold; inverted lanes show the newer capture
      wait_p(1'b1, 6);
      chk(32'(column_comparator_bus), 32'h9);
      chk(32'(column_comparator_bus & 4'h5), 32'h1);
      // Mid-phase write waits for the next phase boundary
      ahb(1'b1, 32'(SCB_OFF_B11_CTRL0), 32'h80);
      repeat (4) @(posedge clk_i);
      chk(32'(fb[0]), 32'h10);
      wait_p(1'b0, 5);
      chk(32'(fb[0]), 32'h20);
      chk(32'(au[0]), 32'h0);
      // Sample-hold disable connects normal lanes early in phase two
      ahb(1'b1, 32'(SCB_OFF_CLK_SEL), 32'h40);
      wait_p(1'b1, 6);
      chk(32'(bus_con), 32'h5);
      ahb(1'b0, 32'(SCB_OFF_STATUS), 32'h0);
      // Phase two synced high, normal lanes connected, buses 1100
      chk(rd, 32'h0000_025C);
      tally_and_finish();
   end
endmodule
`default_nettype wire
